//--- shared/icst_pkg.sv
// package: constants, register map and types of the command and sync timing block
package icst_pkg;

  // ****************************************
  // clock and durations
  // ****************************************
  localparam int CLK_MHZ            = 100;
  localparam int MS_CYC             = CLK_MHZ * 1000;
  localparam int POWER_UP_MS        = 252;
  localparam int HW_RESET_MS        = 193;
  localparam int SW_RESET_MS        = 193;
  localparam int NV_UPDATE_MS       = 72;
  localparam int NV_TEST_MS         = 32;
  localparam int RESTORE_MS         = 142;
  localparam int SELF_TEST_MS       = 14;
  localparam int SAMPLE_SPS         = 2000;
  localparam int SYNC_TO_READY_US   = 256;
  localparam int RESET_LOW_MIN_US   = 10;
  localparam int DR_HIGH_US         = 20;
  localparam int POWER_UP_CYC       = POWER_UP_MS * MS_CYC;
  localparam int HW_RESET_CYC       = HW_RESET_MS * MS_CYC;
  localparam int SW_RESET_CYC       = SW_RESET_MS * MS_CYC;
  localparam int NV_UPDATE_CYC      = NV_UPDATE_MS * MS_CYC;
  localparam int NV_TEST_CYC        = NV_TEST_MS * MS_CYC;
  localparam int RESTORE_CYC        = RESTORE_MS * MS_CYC;
  localparam int SAMPLE_CYC         = (CLK_MHZ * 1000000) / SAMPLE_SPS;
  localparam int SELF_TEST_SAMPLES  = (SELF_TEST_MS * SAMPLE_SPS) / 1000;
  localparam int SYNC_DELAY_CYC     = SYNC_TO_READY_US * CLK_MHZ;
  localparam int RESET_LOW_MIN_CYC  = RESET_LOW_MIN_US * CLK_MHZ;
  localparam int DR_HIGH_CYC        = DR_HIGH_US * CLK_MHZ;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] OFF_GLOBAL_CMD = 12'h000;
  localparam logic [11:0] OFF_MISC_CTRL  = 12'h004;
  localparam logic [11:0] OFF_STATE      = 12'h008;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h010;

  // ****************************************
  // fields
  // ****************************************
  localparam int CMD_RESTORE_BIT    = 1;
  localparam int CMD_SELF_TEST_BIT  = 2;
  localparam int CMD_NV_UPDATE_BIT  = 3;
  localparam int CMD_NV_TEST_BIT    = 4;
  localparam int CMD_SW_RESET_BIT   = 7;
  localparam int SYNC_MODE_LSB      = 2;
  localparam int SYNC_MODE_MSB      = 4;
  localparam logic [2:0] SYNC_PULSE  = 3'b101;
  localparam logic [2:0] SYNC_DIRECT = 3'b001;
  localparam logic [15:0] MISC_RESET = 16'h0000;
  localparam int IRQ_CMD_DONE       = 0;
  localparam int IRQ_READY          = 1;
  localparam int IRQ_SYNC_MISS      = 2;
  localparam int IRQ_W              = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_RECOVER,
    ST_HOLD,
    ST_BUSY,
    ST_RUN
  } icst_state_t;

endpackage : icst_pkg

//--- verilog/icst_core.sv
// module: global command sequencing, reset recovery and sync pacing with apb registers
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module icst_core
  import icst_pkg::*;
#(
  parameter int POWER_UP_CYC_P   = POWER_UP_CYC,
  parameter int HW_RESET_CYC_P   = HW_RESET_CYC,
  parameter int SW_RESET_CYC_P   = SW_RESET_CYC,
  parameter int NV_UPDATE_CYC_P  = NV_UPDATE_CYC,
  parameter int NV_TEST_CYC_P    = NV_TEST_CYC,
  parameter int RESTORE_CYC_P    = RESTORE_CYC,
  parameter int SAMPLE_CYC_P     = SAMPLE_CYC,
  parameter int SYNC_DELAY_CYC_P = SYNC_DELAY_CYC,
  parameter int SELF_TEST_SMP_P  = SELF_TEST_SAMPLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device pins
  input  wire logic        reset_pin_n,
  input  wire logic        sync_pin,
  output logic             data_ready_pin,
  // interrupt
  output logic             irq
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic rst_s1, rst_s2;
  logic sync_s1, sync_s2, sync_s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1  <= 1'b1;
      rst_s2  <= 1'b1;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      rst_s1  <= reset_pin_n;
      rst_s2  <= rst_s1;
      sync_s1 <= sync_pin;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  wire sync_edge = sync_s2 & ~sync_s3;

  // ****************************************
  // apb decode
  // ****************************************
  icst_state_t       state;
  logic [31:0]       wait_cnt;
  logic [15:0]       samp_left;
  logic [7:0]        cmd_bits;
  logic [15:0]       misc;
  logic [15:0]       nv_shadow;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [31:0]       sync_cnt;
  logic [31:0]       samp_cnt;
  logic [15:0]       rst_low_cnt;
  logic [15:0]       dr_cnt;

  wire acc_phase = psel & penable & ~pready;
  wire xfer_done = psel & penable & pready;
  wire sel_cmd   = (paddr == OFF_GLOBAL_CMD);
  wire sel_misc  = (paddr == OFF_MISC_CTRL);
  wire sel_state = (paddr == OFF_STATE);
  wire sel_stat  = (paddr == OFF_IRQ_STATUS);
  wire sel_mask  = (paddr == OFF_IRQ_MASK);
  wire addr_hit  = sel_cmd | sel_misc | sel_state | sel_stat | sel_mask;
  wire wr_cmd    = xfer_done & pwrite & sel_cmd;
  wire wr_misc   = xfer_done & pwrite & sel_misc;
  wire wr_mask   = xfer_done & pwrite & sel_mask;
  wire rd_stat   = xfer_done & ~pwrite & sel_stat;

  wire in_run    = (state == ST_RUN);
  wire [31:0] state_word = {20'h0, sync_cnt != 32'h0, state == ST_HOLD,
                            state == ST_RECOVER, state == ST_BUSY, cmd_bits};
  wire [31:0] rd_data = sel_misc  ? {16'h0, misc} :
                        sel_state ? state_word :
                        sel_stat  ? {{(32-IRQ_W){1'b0}}, irq_stat} :
                        sel_mask  ? {{(32-IRQ_W){1'b0}}, irq_mask} : 32'h0;

  // one wait cycle: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc_phase;
      pslverr <= acc_phase & ~addr_hit;
      prdata  <= acc_phase && !pwrite ? rd_data : 32'h0;
    end
  end

  // ****************************************
  // command decode, fixed priority
  // ****************************************
  // priority: reset, restore, update, test, self test; other bits ignored
  wire sel_rst  = pwdata[CMD_SW_RESET_BIT];
  wire sel_res  = ~sel_rst & pwdata[CMD_RESTORE_BIT];
  wire sel_upd  = ~sel_rst & ~sel_res & pwdata[CMD_NV_UPDATE_BIT];
  wire sel_tst  = ~sel_rst & ~sel_res & ~sel_upd & pwdata[CMD_NV_TEST_BIT];
  wire sel_self = ~sel_rst & ~sel_res & ~sel_upd & ~sel_tst & pwdata[CMD_SELF_TEST_BIT];
  wire [7:0] cmd_sel = {sel_rst, 2'b00, sel_tst, sel_upd, sel_self, sel_res, 1'b0};
  // commands outside the run state are dropped; host must wait them out
  wire cmd_go   = wr_cmd & in_run & (|cmd_sel);
  wire [31:0] cmd_cyc = sel_res ? 32'(RESTORE_CYC_P) :
                        sel_upd ? 32'(NV_UPDATE_CYC_P) :
                        32'(NV_TEST_CYC_P);

  // ****************************************
  // sample pacing and sync
  // ****************************************
  wire [2:0] sync_mode = misc[SYNC_MODE_MSB:SYNC_MODE_LSB];
  wire sync_on   = (sync_mode == SYNC_PULSE) | (sync_mode == SYNC_DIRECT);
  wire samp_tick = (samp_cnt == 32'(SAMPLE_CYC_P - 1));
  // a slow sync clock stretches anything counted in samples
  wire samp_evt  = sync_on ? sync_edge : samp_tick;
  wire sync_take = sync_on & sync_edge & (sync_cnt == 32'h0);
  wire sync_miss = sync_on & sync_edge & (sync_cnt != 32'h0);
  wire dr_start  = in_run & (sync_on ? (sync_cnt == 32'h1) : samp_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_cnt <= 32'h0;
    end else begin
      samp_cnt <= samp_tick || sync_on ? 32'h0 : samp_cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt <= 32'h0;
    end else if (sync_take) begin
      sync_cnt <= 32'(SYNC_DELAY_CYC_P);
    end else if (sync_cnt != 32'h0) begin
      sync_cnt <= sync_cnt - 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_cnt         <= 16'h0;
      data_ready_pin <= 1'b0;
    end else if (dr_start) begin
      dr_cnt         <= 16'(DR_HIGH_CYC);
      data_ready_pin <= 1'b1;
    end else if (dr_cnt != 16'h0) begin
      dr_cnt         <= dr_cnt - 16'h1;
      data_ready_pin <= (dr_cnt != 16'h1);
    end
  end

  // ****************************************
  // reset pin qualification
  // ****************************************
  // glitches shorter than the minimum low time do not reset
  wire hold_evt = ~rst_s2 & (rst_low_cnt == 16'(RESET_LOW_MIN_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_low_cnt <= 16'h0;
    end else if (rst_s2) begin
      rst_low_cnt <= 16'h0;
    end else if (rst_low_cnt != 16'(RESET_LOW_MIN_CYC)) begin
      rst_low_cnt <= rst_low_cnt + 16'h1;
    end
  end

  // ****************************************
  // command and recovery sequencer
  // ****************************************
  icst_state_t next_state;
  logic [31:0] next_wait;
  logic [15:0] next_samp_left;
  logic [7:0]  next_cmd;
  logic [15:0] next_misc;
  logic [15:0] next_nv;
  logic        done_evt;
  logic        ready_evt;

  always_comb begin
    next_state     = state;
    next_wait      = (wait_cnt != 32'h0) ? wait_cnt - 32'h1 : 32'h0;
    next_samp_left = samp_left;
    next_cmd       = cmd_bits;
    next_misc      = (wr_misc && in_run) ? pwdata[15:0] : misc;
    next_nv        = nv_shadow;
    done_evt       = 1'b0;
    ready_evt      = 1'b0;
    case (state)
      ST_RECOVER: begin
        if (wait_cnt == 32'h1) begin
          next_state = ST_RUN;
          next_cmd   = 8'h0;
          ready_evt  = 1'b1;
        end
      end
      ST_HOLD: begin
        if (rst_s2) begin
          next_state = ST_RECOVER;
          next_wait  = 32'(HW_RESET_CYC_P);
          next_misc  = nv_shadow;
        end
      end
      ST_BUSY: begin
        if (cmd_bits[CMD_SELF_TEST_BIT]) begin
          if (samp_evt) begin
            next_samp_left = samp_left - 16'h1;
            if (samp_left == 16'h1) begin
              next_state = ST_RUN;
              next_cmd   = 8'h0;
              done_evt   = 1'b1;
            end
          end
        end else if (wait_cnt == 32'h1) begin
          next_state = ST_RUN;
          next_cmd   = 8'h0;
          done_evt   = 1'b1;
          if (cmd_bits[CMD_NV_UPDATE_BIT]) begin
            next_nv = misc;
          end
          if (cmd_bits[CMD_RESTORE_BIT]) begin
            next_misc = MISC_RESET;
            next_nv   = MISC_RESET;
          end
        end
      end
      ST_RUN: begin
        if (cmd_go) begin
          next_cmd = cmd_sel;
          if (sel_rst) begin
            next_state = ST_RECOVER;
            next_wait  = 32'(SW_RESET_CYC_P);
            next_misc  = nv_shadow;
          end else begin
            next_state     = ST_BUSY;
            next_wait      = sel_self ? 32'h0 : cmd_cyc;
            next_samp_left = 16'(SELF_TEST_SMP_P);
          end
        end
      end
      default: begin
        next_state = ST_RECOVER;
      end
    endcase
    if (hold_evt) begin
      next_state = ST_HOLD;
      next_cmd   = 8'h0;
      next_wait  = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_RECOVER;
      wait_cnt  <= 32'(POWER_UP_CYC_P);
      samp_left <= 16'h0;
      cmd_bits  <= 8'h0;
      misc      <= MISC_RESET;
      nv_shadow <= MISC_RESET;
    end else begin
      state     <= next_state;
      wait_cnt  <= next_wait;
      samp_left <= next_samp_left;
      cmd_bits  <= next_cmd;
      misc      <= next_misc;
      nv_shadow <= next_nv;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  // clearing only the bits returned keeps events between capture and clear
  wire [IRQ_W-1:0] irq_set  = {sync_miss, ready_evt, done_evt};
  wire [IRQ_W-1:0] irq_clr  = rd_stat ? prdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  wire [IRQ_W-1:0] next_irq_mask = wr_mask ? pwdata[IRQ_W-1:0] : irq_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {IRQ_W{1'b0}};
      irq_mask <= IRQ_MASK_RESET;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq      <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_sw_reset_time: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && sel_rst |=> state == ST_RECOVER && wait_cnt == 32'(SW_RESET_CYC_P))
    else $error("software reset did not load its recovery time");
  a_update_time: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && sel_upd && !hold_evt |=> state == ST_BUSY && wait_cnt == 32'(NV_UPDATE_CYC_P))
    else $error("update command did not load its duration");
  a_test_time: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && sel_tst && !hold_evt |=> state == ST_BUSY && wait_cnt == 32'(NV_TEST_CYC_P))
    else $error("storage test did not load its duration");
  a_restore_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_BUSY && cmd_bits[CMD_RESTORE_BIT] && wait_cnt == 32'h1 && !hold_evt
    |=> misc == MISC_RESET && nv_shadow == MISC_RESET && state == ST_RUN)
    else $error("factory restore did not reload defaults");
  a_self_test_len: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && sel_self && !hold_evt |=> samp_left == 16'(SELF_TEST_SMP_P))
    else $error("self test sample count wrong");
  a_self_test_wait: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_BUSY && cmd_bits[CMD_SELF_TEST_BIT] && !samp_evt && !hold_evt
    |=> state == ST_BUSY && $stable(samp_left))
    else $error("self test advanced without a sample");
  a_hw_reset_time: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_HOLD && rst_s2 |=> state == ST_RECOVER && wait_cnt == 32'(HW_RESET_CYC_P))
    else $error("pin reset recovery time wrong");
  a_recover_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RECOVER && wait_cnt == 32'h1 && !hold_evt
    |=> state == ST_RUN && irq_stat[IRQ_READY])
    else $error("recovery did not end in the run state");
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    sync_take |=> sync_cnt == 32'(SYNC_DELAY_CYC_P))
    else $error("sync to ready delay not loaded");
  a_sync_ready: assert property (@(posedge pclk) disable iff (!presetn)
    sync_cnt == 32'h1 && in_run && sync_on |=> data_ready_pin ##1 data_ready_pin)
    else $error("data ready missing after sync delay");
  a_mode_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode == SYNC_PULSE || sync_mode == SYNC_DIRECT) && sync_cnt != 32'h1
    |=> !$rose(data_ready_pin))
    else $error("sync mode let the internal tick start data ready");
  a_ready_rate: assert property (@(posedge pclk) disable iff (!presetn)
    dr_start |-> in_run && (sync_on || samp_cnt == 32'(SAMPLE_CYC_P - 1)))
    else $error("data ready outside sample timing");

endmodule : icst_core

//--- verification/icst_host_model.sv
// host-side model that drives the reset and sync pins of the timing block
`timescale 1ns/1ps
module icst_host_model (
  // clock
  input  wire logic pclk,
  // device pins
  output logic      reset_pin_n,
  output logic      sync_pin
);
  initial begin
    reset_pin_n = 1'b1;
    sync_pin    = 1'b0;
  end
  // widths under 500 cycles break the sync minimum, used only on purpose
  task automatic sync_pulse(input int high_cyc);
    @(posedge pclk);
    sync_pin <= 1'b1;
    repeat (high_cyc) @(posedge pclk);
    sync_pin <= 1'b0;
  endtask : sync_pulse
  task automatic reset_hold(input int low_cyc);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (low_cyc) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask : reset_hold
endmodule : icst_host_model

//--- verification/icst_core_bench.sv
// self-checking bench of the command, reset and sync timing block
`timescale 1ns/1ps
module icst_core_bench
  import icst_pkg::*;
;
  // ****************************************
  // shortened counts
  // ****************************************
  localparam int PU = 500;
  localparam int HW = 500;
  localparam int SW = 500;
  localparam int NU = 300;
  localparam int NT = 200;
  localparam int RS = 400;
  localparam int SM = 3000;
  localparam int SD = 1200;
  localparam int LIMIT = 90000;
  typedef struct packed {
    int          bitn;
    int          lo;
    int          hi;
    logic [2:0]  irqs;
    logic [15:0] misc;
  } icst_row_t;
  // restore clears both copies, so self test runs on the internal tick
  localparam icst_row_t ROWS [5] = '{
    '{CMD_NV_UPDATE_BIT, NU - 2, NU + 14, 3'h1, 16'h0014},
    '{CMD_NV_TEST_BIT, NT - 2, NT + 14, 3'h1, 16'h0014},
    '{CMD_SW_RESET_BIT, SW - 2, SW + 14, 3'h2, 16'h0014},
    '{CMD_RESTORE_BIT, RS - 2, RS + 14, 3'h1, 16'h0000},
    '{CMD_SELF_TEST_BIT, 2 * SM, 3 * SM + 14, 3'h1, 16'h0000}
  };
  logic        pclk    = 1'b0;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reset_pin_n;
  logic        sync_pin;
  logic        data_ready_pin;
  logic        irq;
  logic [31:0] rdat;
  logic        err;
  int          cyc         = 0;
  int          fail_count  = 0;
  int          check_count = 0;
  int          t0;
  int          d;

  always #5 pclk = ~pclk;

  icst_core #(
    .POWER_UP_CYC_P(PU), .HW_RESET_CYC_P(HW), .SW_RESET_CYC_P(SW),
    .NV_UPDATE_CYC_P(NU), .NV_TEST_CYC_P(NT), .RESTORE_CYC_P(RS),
    .SAMPLE_CYC_P(SM), .SYNC_DELAY_CYC_P(SD), .SELF_TEST_SMP_P(3)
  ) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n), .sync_pin(sync_pin),
    .data_ready_pin(data_ready_pin), .irq(irq)
  );
  icst_host_model host (.pclk(pclk), .reset_pin_n(reset_pin_n), .sync_pin(sync_pin));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic check_rng(input string name, input int lo, input int hi, input int v);
    check_count++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, v);
    end
  endtask : check_rng
  // polling is coarse, hence the tolerance of a few cycles on every duration timed through wait_idle except the self tests
  // reset held counts as not idle, so a poll right after the pin rises waits on
  task automatic wait_idle();
    do apb(1'b0, OFF_STATE, 32'h0); while (rdat[10:8] !== 3'b000);
    d = cyc - t0;
  endtask : wait_idle

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("[FAIL] run length expected done seen hang");
      conclude();
    end
  end

  initial begin
    presetn <= 1'b0;
    paddr   <= 12'h000;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    pwdata  <= 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    apb(1'b0, OFF_STATE, 32'h0);
    check("recovering", 32'h200, rdat & 32'h00000f00);
    foreach (ROWS[i]) begin
      // state word shows recovery here, so the command offset stands in for it
      apb(1'b0, i == 1 ? OFF_GLOBAL_CMD : 12'(i * 4 + 4), 32'h0);
      check("reset value", 32'h0, rdat);
    end
    apb(1'b1, OFF_GLOBAL_CMD, 32'h8);
    apb(1'b1, OFF_MISC_CTRL, 32'h14);
    wait_idle();
    check_rng("power-up time", PU - 2, PU + 14, d);
    apb(1'b0, OFF_MISC_CTRL, 32'h0);
    check("misc dropped", 32'h0, rdat);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    check("ready bit", 32'h2, rdat);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFF_MISC_CTRL, 32'(m * 8));
      while (data_ready_pin !== 1'b0) @(posedge pclk);
      while (data_ready_pin !== 1'b1) @(posedge pclk);
      t0 = cyc;
      while (data_ready_pin !== 1'b0) @(posedge pclk);
      check_rng("ready width", DR_HIGH_CYC, DR_HIGH_CYC, cyc - t0);
      while (data_ready_pin !== 1'b1) @(posedge pclk);
      check_rng("ready period", SM, SM, cyc - t0);
    end
    apb(1'b1, OFF_MISC_CTRL, 32'h14);
    foreach (ROWS[i]) begin
      apb(1'b1, OFF_GLOBAL_CMD, 32'h1 << ROWS[i].bitn);
      t0 = cyc;
      wait_idle();
      check_rng("command time", ROWS[i].lo, ROWS[i].hi, d);
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      check("done bits", 32'(ROWS[i].irqs), rdat);
      apb(1'b0, OFF_MISC_CTRL, 32'h0);
      check("misc after", 32'(ROWS[i].misc), rdat);
      check("masked irq", 32'h0, 32'(irq));
      repeat (16 * CLK_MHZ) @(posedge pclk);
    end
    // commands and misc writes while busy must be dropped
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    apb(1'b0, OFF_IRQ_MASK, 32'h0);
    check("mask", 32'h1, rdat);
    apb(1'b1, OFF_GLOBAL_CMD, 32'h10);
    t0 = cyc;
    apb(1'b1, OFF_GLOBAL_CMD, 32'h8);
    apb(1'b1, OFF_MISC_CTRL, 32'h1c);
    wait_idle();
    check_rng("busy refusal", NT - 2, NT + 14, d);
    repeat (2) @(posedge pclk);
    check("irq raised", 32'h1, 32'(irq));
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    check("irq cleared", 32'h0, 32'(irq));
    apb(1'b0, OFF_MISC_CTRL, 32'h0);
    check("misc busy", 32'h0, rdat);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFF_MISC_CTRL, m ? 32'h04 : 32'h14);
      while (data_ready_pin !== 1'b0) @(posedge pclk);
      fork host.sync_pulse(600); join_none
      while (sync_pin !== 1'b1) @(posedge pclk);
      t0 = cyc;
      while (data_ready_pin !== 1'b1) @(posedge pclk);
      check_rng("sync delay", SD, SD + 8, cyc - t0);
      repeat (3000) @(posedge pclk);
    end
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    fork
      begin
        host.sync_pulse(600);
        repeat (100) @(posedge pclk);
        host.sync_pulse(600);
      end
    join_none
    repeat (3000) @(posedge pclk);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    check("sync missed", 32'h4, rdat & 32'h4);
    fork
      repeat (4) begin
        host.sync_pulse(600);
        repeat (4400) @(posedge pclk);
      end
    join_none
    apb(1'b1, OFF_GLOBAL_CMD, 32'h4);
    t0 = cyc;
    wait_idle();
    check_rng("slow self test", 10000, 15100, d);
    apb(1'b1, OFF_MISC_CTRL, 32'h08);
    host.reset_hold(500);
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATE, 32'h0);
    check("short reset", 32'h0, rdat & 32'h00000700);
    host.reset_hold(1100);
    t0 = cyc;
    wait_idle();
    check_rng("pin recovery", HW - 2, HW + 14, d);
    apb(1'b0, OFF_MISC_CTRL, 32'h0);
    check("misc reload", 32'h0, rdat);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", 32'h1, {rdat[30:0], err});
    apb(1'b1, OFF_IRQ_MASK, 32'h7);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("outputs in reset", 32'h0, {30'h0, data_ready_pin, irq});
    presetn <= 1'b1;
    apb(1'b0, OFF_IRQ_MASK, 32'h0);
    check("mask after reset", 32'h0, rdat);
    conclude();
  end
endmodule : icst_core_bench
